/* mcu_clock_tree.sv */
// Functional notes
// - One of four oscillator sources is selected and fed to the clock divider.
// - The CPU clock is the divider output, so the oscillator clock may be slowed first.
// - A machine cycle spans two CPU clock cycles, giving two or four CPU clocks per instruction.
// - The peripheral clock runs at half the CPU clock rate.
// - An internal RC oscillator near 7.373 MHz is one of the selectable sources.
// - The tune register sits at 96H with clock-out enable in bit 6, tune in bits 5..0, bit 7 unused.
// - Only power-on reset loads the factory tune value; other resets leave the register alone.
// - Software may rewrite the six-bit tune field at any time to retune the RC oscillator.
// - With clock-out enabled and no crystal in use, a clock at half the CPU rate is driven out.
// - The divider slows the oscillator by up to 510 and may be changed at any time.
`include "mcu_clock_regs.svh"

module mcu_clock_tree
	import mcu_clock_pkg::*;
#(
	parameter trim_t FACTORY_TRIM = 7'h20
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic porReset,
	input wire osc_src_e oscSource,
	input wire logic wdOscTick,
	input wire logic xtalTick,
	input wire logic extClkTick,
	input wire logic rtcUsesXtal,
	input wire logic [7:0] clockDividerSetting,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic sfrRead,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	output logic oscTick,
	output logic cpuTick,
	output logic machineTick,
	output logic periphTick,
	output logic clockOutPin,
	output logic clockOutOen
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Divide by 2*N, or by one for a setting of zero.
	function automatic div_cnt_t divLimit(input logic [7:0] n);
		divLimit = (n == 8'h00) ? 9'h000 : 9'({n, 1'b0} - 9'h001);
	endfunction

	function automatic logic isTrimAddr(input logic [7:0] a);
		isTrimAddr = (a == `TRIM_ADDR);
	endfunction

	// ----------------------------------------------------------------
	// Tune register
	// ----------------------------------------------------------------
	logic rcTick;
	trim_t trim_q, trim_d;
	logic [7:0] rdata_d;

	always_comb begin
		trim_d = trim_q;
		if (porReset) begin
			trim_d = FACTORY_TRIM;
		end else if (sfrWrite && isTrimAddr(sfrAddr)) begin
			trim_d = sfrWdata[6:0];
		end
		rdata_d = 8'h00;
		if (sfrRead && isTrimAddr(sfrAddr)) begin
			rdata_d = {1'b0, trim_q};
		end
	end

	// The tune register ignores rstn so that only power-on reset restores it.
	always_ff @(posedge clk) begin
		trim_q <= trim_d;
	end

	always_ff @(posedge clk) begin
		if (!rstn || porReset) begin
			sfrRdata <= 8'h00;
		end else begin
			sfrRdata <= rdata_d;
		end
	end

	rc_osc_model rcOsc (
		.clk(clk),
		.rstn(rstn && !porReset),
		.tune(trim_q[`TRIM_TUNE_MSB:0]),
		.rcTick(rcTick)
	);

	// ----------------------------------------------------------------
	// Source select, divider and derived enables
	// ----------------------------------------------------------------
	logic oscEvt, crystalInUse, outEnable;
	div_cnt_t divCnt_q, divCnt_d;
	logic phase_q, phase_d, cpu_d, machine_d, periph_d, pin_d, oen_d;

	always_comb begin
		unique case (oscSource)
			SRC_RC: oscEvt = rcTick;
			SRC_WDOG: oscEvt = wdOscTick;
			SRC_XTAL: oscEvt = xtalTick;
			SRC_EXT: oscEvt = extClkTick;
		endcase
		crystalInUse = (oscSource == SRC_XTAL) || rtcUsesXtal;
		outEnable = trim_q[`TRIM_CLKOUT_EN_BIT] && !crystalInUse;
		divCnt_d = divCnt_q;
		cpu_d = 1'b0;
		if (oscEvt) begin
			// A compare rather than equality lets a new setting take effect at once.
			if (divCnt_q >= divLimit(clockDividerSetting)) begin
				divCnt_d = 9'h000;
				cpu_d = 1'b1;
			end else begin
				divCnt_d = 9'(divCnt_q + 9'h001);
			end
		end
		phase_d = cpu_d ? !phase_q : phase_q;
		machine_d = cpu_d && phase_q;
		periph_d = cpu_d && !phase_q;
		pin_d = 1'b0;
		if (outEnable) begin
			pin_d = cpu_d ? !clockOutPin : clockOutPin;
		end
		oen_d = !outEnable;
	end

	always_ff @(posedge clk) begin
		if (!rstn || porReset) begin
			divCnt_q <= 9'h000;
			phase_q <= 1'b0;
			oscTick <= 1'b0;
			cpuTick <= 1'b0;
			machineTick <= 1'b0;
			periphTick <= 1'b0;
			clockOutPin <= 1'b0;
			clockOutOen <= 1'b1;
		end else begin
			divCnt_q <= divCnt_d;
			phase_q <= phase_d;
			oscTick <= oscEvt;
			cpuTick <= cpu_d;
			machineTick <= machine_d;
			periphTick <= periph_d;
			clockOutPin <= pin_d;
			clockOutOen <= oen_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	trim_por_a: assert property (@(posedge clk)
		porReset |=> trim_q == FACTORY_TRIM) else $error("tune not loaded by power-on");

	trim_keep_a: assert property (@(posedge clk) disable iff (porReset)
		(!rstn && !sfrWrite) |=> $stable(trim_q)) else $error("tune changed by reset");

	trim_write_a: assert property (@(posedge clk) disable iff (porReset)
		(sfrWrite && sfrAddr == `TRIM_ADDR) |=> trim_q == 7'($past(sfrWdata)))
		else $error("tune write lost");

	trim_read_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		(sfrRead && sfrAddr == `TRIM_ADDR) |=> sfrRdata == {1'b0, $past(trim_q)})
		else $error("tune read wrong");

	rdata_top_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		!sfrRdata[7]) else $error("unused tune bit read as one");

	src_sel_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		(oscSource == SRC_WDOG && wdOscTick) |=> oscTick) else $error("source not routed");

	src_any_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		oscEvt |=> oscTick) else $error("oscillator tick lost");

	src_quiet_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		(oscSource == SRC_EXT && !extClkTick) |=> !oscTick)
		else $error("unselected tick passed");

	cpu_osc_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		cpuTick |-> $past(oscEvt)) else $error("cpu tick without oscillator tick");

	div_one_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		(clockDividerSetting == 8'h00 && oscEvt) |=> cpuTick) else $error("divide by one");

	div_two_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		(clockDividerSetting == 8'h01 && $stable(clockDividerSetting) && cpuTick
		&& $past(oscEvt) && oscEvt) |=> !cpuTick) else $error("divide by two");

	div_range_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		divCnt_q <= 9'(`DIV_MAX - 1)) else $error("divider count out of range");

	machine_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		machineTick |-> cpuTick && !periphTick) else $error("machine tick off cpu");

	periph_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		periphTick |-> cpuTick) else $error("peripheral tick off cpu");

	cpu_kind_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		cpuTick |-> machineTick != periphTick) else $error("cpu tick not paired");

	clkout_off_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		crystalInUse |=> clockOutOen && !clockOutPin) else $error("clock out with crystal");

	clkout_tog_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		(cpuTick && $past(outEnable) && !clockOutOen && !$past(clockOutOen))
		|-> clockOutPin != $past(clockOutPin)) else $error("clock out not toggled");

	clkout_step_a: assert property (@(posedge clk) disable iff (!rstn || porReset)
		($changed(clockOutPin) && !clockOutOen && !$past(clockOutOen)) |-> cpuTick)
		else $error("clock out moved off cpu tick");

	// ----------------------------------------------------------------
	// Cover points
	// ----------------------------------------------------------------
	cover_div_c: cover property (@(posedge clk) clockDividerSetting > 8'h02 ##0 cpuTick);
	cover_out_c: cover property (@(posedge clk) !clockOutOen ##1 clockOutPin);
	cover_trim_c: cover property (@(posedge clk) sfrWrite && sfrAddr == `TRIM_ADDR);
	cover_rc_c: cover property (@(posedge clk) oscSource == SRC_RC ##0 cpuTick);
	cover_por_c: cover property (@(posedge clk) porReset ##1 !porReset);

endmodule

/* mcu_clock_regs.svh */
`ifndef MCU_CLOCK_REGS_SVH
`define MCU_CLOCK_REGS_SVH

// ----------------------------------------------------------------
// Register map and timing
// ----------------------------------------------------------------
`define TRIM_ADDR 8'h96
`define TRIM_CLKOUT_EN_BIT 6
`define TRIM_TUNE_MSB 5
`define TRIM_TUNE_CENTER 6'h20
`define CLK_FREQ_KHZ 50000
`define RC_FREQ_KHZ 7373
`define RC_ACC_BITS 16
`define RC_TUNE_SLOPE 16'h0040
`define DIV_MAX 510
`define CPU_PER_MACHINE 2

`endif

/* mcu_clock_pkg.sv */
package mcu_clock_pkg;

	typedef enum logic [1:0] {
		SRC_RC = 2'h0,
		SRC_WDOG = 2'h1,
		SRC_XTAL = 2'h3,
		SRC_EXT = 2'h2
	} osc_src_e;

	typedef logic [6:0] trim_t;
	typedef logic [8:0] div_cnt_t;

endpackage

/* rc_osc_model.sv */
`include "mcu_clock_regs.svh"

module rc_osc_model
	import mcu_clock_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [5:0] tune,
	output logic rcTick
);

	localparam logic [15:0] NOM_STEP =
		16'((`RC_FREQ_KHZ * (2 ** `RC_ACC_BITS)) / `CLK_FREQ_KHZ);

	logic [15:0] acc_q, acc_d;
	logic rcTick_d;
	logic [16:0] sum;
	logic [15:0] step;

	// Phase accumulator: each carry out is one RC oscillator edge; tune trims the step.
	always_comb begin
		step = 16'(NOM_STEP + {10'h000, tune} * `RC_TUNE_SLOPE
			- {10'h000, `TRIM_TUNE_CENTER} * `RC_TUNE_SLOPE);
		sum = {1'b0, acc_q} + {1'b0, step};
		acc_d = sum[15:0];
		rcTick_d = sum[16];
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			acc_q <= 16'h0000;
			rcTick <= 1'b0;
		end else begin
			acc_q <= acc_d;
			rcTick <= rcTick_d;
		end
	end

	rc_sparse_a: assert property (@(posedge clk) disable iff (!rstn)
		rcTick |=> !rcTick) else $error("rc tick on two cycles in a row");

endmodule

/* test_mcu_clock_tree.sv */
module test_mcu_clock_tree;
	import mcu_clock_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 0, rstn = 0, porReset = 1, wdOscTick = 0, xtalTick = 0, extClkTick = 0;
	logic rtcUsesXtal = 0, sfrWrite = 0, sfrRead = 0, pinQ = 0;
	logic [7:0] clockDividerSetting = 8'h00, sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
	osc_src_e oscSource = SRC_EXT;
	logic oscTick, cpuTick, machineTick, periphTick, clockOutPin, clockOutOen;
	int nErrors = 0, nChecks = 0, cOsc = 0, cCpu = 0, cPer = 0, cMac = 0, cTog = 0, base;

	mcu_clock_tree u_dut (.clk, .rstn, .porReset, .oscSource, .wdOscTick, .xtalTick,
		.extClkTick, .rtcUsesXtal, .clockDividerSetting, .sfrAddr, .sfrWrite, .sfrRead,
		.sfrWdata, .sfrRdata, .oscTick, .cpuTick, .machineTick, .periphTick, .clockOutPin,
		.clockOutOen);

	initial begin
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Output pulse counters
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cOsc += oscTick;
		cCpu += cpuTick;
		cPer += periphTick;
		cMac += machineTick;
		cTog += (clockOutPin != pinQ);
		pinQ = clockOutPin;
	end

	task automatic check(input string what, input logic [31:0] exp, got);
		nChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		sfrAddr <= a;
		sfrWdata <= d;
		sfrWrite <= 1'b1;
		@(posedge clk);
		sfrWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, exp);
		@(posedge clk);
		sfrAddr <= a;
		sfrRead <= 1'b1;
		@(posedge clk);
		sfrRead <= 1'b0;
		#1 check("rdata", exp, sfrRdata);
	endtask

	// Selected source ticks on even cycles, the other sources on odd cycles.
	task automatic run(input osc_src_e s, input logic [7:0] n, input int k, input logic rtc);
		int b[5];
		int c;
		logic off;
		@(posedge clk);
		oscSource <= s;
		clockDividerSetting <= n;
		rtcUsesXtal <= rtc;
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1 b = '{cOsc, cCpu, cPer, cMac, cTog};
		for (int i = 0; i < 2 * k; i++) begin
			@(posedge clk);
			extClkTick <= (s == SRC_EXT) == !i[0];
			xtalTick <= (s == SRC_XTAL) == !i[0];
			wdOscTick <= (s == SRC_WDOG) == !i[0];
		end
		@(posedge clk);
		{extClkTick, xtalTick, wdOscTick} <= 3'h0;
		repeat (6) @(posedge clk);
		#1 off = (s == SRC_XTAL) || rtc;
		c = k / (n == 8'h00 ? 1 : 2 * n);
		check("osc", k, cOsc - b[0]);
		check("cpu", c, cCpu - b[1]);
		check("periph", (c + 1) / 2, cPer - b[2]);
		check("machine", c / 2, cMac - b[3]);
		check("clkout", off ? 0 : c, cTog - b[4]);
		check("oen", off, clockOutOen);
	endtask

	task automatic rcRate(input int lo, hi);
		base = cOsc;
		repeat (1000) @(posedge clk);
		#1 check("rc rate", 1, (cOsc - base >= lo) && (cOsc - base <= hi));
	endtask

	task automatic finishTest();
		$display("Checks %0d errors %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		nErrors++;
		finishTest();
	end

	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		porReset <= 1'b0;
		rd(8'h96, 8'h20);
		wr(8'h96, 8'hc5);
		rd(8'h96, 8'h45);
		wr(8'h97, 8'hff);
		rd(8'h97, 8'h00);
		rd(8'h96, 8'h45);
		run(SRC_EXT, 8'h00, 10, 1'b0);
		rd(8'h96, 8'h45);
		run(SRC_WDOG, 8'h01, 12, 1'b0);
		run(SRC_XTAL, 8'h02, 20, 1'b0);
		run(SRC_EXT, 8'hff, 1020, 1'b1);
		run(SRC_EXT, 8'h03, 24, 1'b0);
		// Back-to-back source ticks at divide by two give one CPU tick per two.
		@(posedge clk);
		clockDividerSetting <= 8'h01;
		extClkTick <= 1'b1;
		#1 base = cCpu;
		repeat (8) @(posedge clk);
		extClkTick <= 1'b0;
		repeat (4) @(posedge clk);
		#1 check("cpu burst", 4, cCpu - base);
		wr(8'h96, 8'h60);
		@(posedge clk);
		oscSource <= SRC_RC;
		rcRate(146, 149);
		wr(8'h96, 8'h3f);
		rcRate(176, 179);
		check("oen off", 1'b1, clockOutOen);
		@(posedge clk);
		porReset <= 1'b1;
		@(posedge clk);
		porReset <= 1'b0;
		rd(8'h96, 8'h20);
		finishTest();
	end
endmodule
